// ==== hdl/adc_ctrl_pkg.sv ====
// Package: constants and types for the converter control block.
// Assumes a single 250 MHz clock domain.
package adc_ctrl_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned POWER_UP_NS_X10 = 15;    // 1.5 us in 100 ns
  localparam int unsigned CONV_TIME_NS_X10 = 45;   // 4.5 us in 100 ns
  // Least time rounds up, longest rounds down
  localparam int unsigned POWER_UP_CYCLES =
    (POWER_UP_NS_X10 * 100000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CONV_CYCLES =
    (CONV_TIME_NS_X10 * 100000) / CLK_PERIOD_PS;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned RESULT_WIDTH = 8;
  localparam int unsigned BIT_STEPS    = 8;
  localparam logic [7:0]  RESULT_RESET = 8'h00;

  typedef enum logic [4:0] {
    ST_DOWN  = 5'b0_0001,
    ST_PWRUP = 5'b0_0010,
    ST_IDLE  = 5'b0_0100,
    ST_CONV  = 5'b0_1000,
    ST_DONE  = 5'b1_0000
  } ctrl_state_t;

endpackage

// ==== hdl/result_if.sv ====
// Interface: result word passing from the controller to the buffer.
// Assumes both ends run on the same clock.
interface result_if #(parameter int unsigned WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ==== hdl/result_buffer.sv ====
// Two-entry skid buffer holding conversion results.
// Assumes one clock and an active-low asynchronous reset.
module result_buffer #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  result_if.sink                up,
  input  wire logic             i_ready,
  output logic                  o_valid,
  output logic [WIDTH-1:0]      o_data
);

  typedef struct packed {
    logic [1:0]       count;
    logic [WIDTH-1:0] word0;
    logic [WIDTH-1:0] word1;
  } buf_state_t;

  buf_state_t state;
  buf_state_t next_state;
  logic       push;
  logic       pop;

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  // Ready only while a slot is free, so the source stalls when full
  assign up.ready = (state.count != 2'd2);
  assign o_valid  = (state.count != 2'd0);
  assign o_data   = state.word0;
  assign push     = up.valid && up.ready;
  assign pop      = o_valid && i_ready;

  // Next state of the two slots
  always_comb begin
    next_state = state;
    if (pop) begin
      next_state.word0 = state.word1;
    end
    if (push) begin
      if (state.count == 2'd0 || (state.count == 2'd1 && pop)) begin
        next_state.word0 = up.data;
      end else begin
        next_state.word1 = up.data;
      end
    end
    next_state.count = 2'(state.count + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// ==== hdl/adc_ctrl.sv ====
// Control logic of an 8-bit sampling converter with a parallel read port.
// Assumes the comparator answer comes from the analog core on this clock,
// and that pin inputs are asynchronous to it.
//
// What this block does
// RULE1 - A rising trigger edge starts an internal low pulse of 1.5 us for power-up.
// RULE2 - A falling trigger edge starts a conversion, or waits for the pulse to end.
// RULE3 - At the end of a conversion the trigger level is sampled for power-down.
// RULE4 - With select and read both low the result is driven onto the bus.
// RULE5 - Busy is high for the whole conversion and low when it completes.
// RULE6 - The eight result outputs are released whenever reading is not enabled.
// RULE7 - At the end of a conversion the track/hold goes back to tracking.
// RULE8 - The host waits the acquisition time before the next trigger.
// RULE9 - A conversion completes within 4.5 us of its start.
// RULE10 - After power-on the block is powered down until a rising trigger edge; trig_sync resets to 000, so a trigger high out of reset also powers it up.
// RULE11 - The result is straight binary, one step per LSB of reference/256.
// RULE12 - Trigger low at completion powers down; trigger high stays powered.
module adc_ctrl (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_conversion_trigger_n,
  input  wire logic       i_select_n,
  input  wire logic       i_read_n,
  input  wire logic       i_comparator,
  output logic            o_busy,
  output logic            o_powered,
  output logic            o_track,
  output logic [7:0]      o_dac_code,
  output logic [7:0]      o_result_bus,
  output logic [7:0]      o_result_bus_oe,
  output logic            o_result_valid
);

  localparam int unsigned PU_W = $clog2(adc_ctrl_pkg::POWER_UP_CYCLES + 1);
  localparam int unsigned CV_W = $clog2(adc_ctrl_pkg::CONV_CYCLES + 1);
  localparam int unsigned STEP_CYCLES =
    adc_ctrl_pkg::CONV_CYCLES / adc_ctrl_pkg::BIT_STEPS;

  initial begin
    if (STEP_CYCLES < 1) begin
      $error("Conversion time too short for the bit steps");
    end
  end

  typedef struct packed {
    adc_ctrl_pkg::ctrl_state_t fsm;
    logic [2:0]                trig_sync;   // Two sync stages plus last
    logic [2:0]                sel_rd_sync0;
    logic [1:0]                sel_rd_sync1;
    logic [PU_W-1:0]           pu_count;
    logic                      fall_pending;
    logic [CV_W-1:0]           conv_count;
    logic [2:0]                bit_index;
    logic [7:0]                trial;
    logic [7:0]                result;
    logic                      push;
  } ctrl_t;

  ctrl_t state;
  ctrl_t next_state;
  logic  trig;
  logic  trig_rise;
  logic  trig_fall;
  logic  read_en;
  logic  step_edge;

  result_if #(.WIDTH(adc_ctrl_pkg::RESULT_WIDTH)) res_link ();

  // ****************************************************************
  // Pin synchronisers and edges
  // ****************************************************************
  // Only the second and third stages are looked at
  assign trig      = state.trig_sync[1];
  assign trig_rise = state.trig_sync[1] && !state.trig_sync[2];
  assign trig_fall = !state.trig_sync[1] && state.trig_sync[2];
  assign read_en   = !state.sel_rd_sync1[0] && !state.sel_rd_sync1[1];
  assign step_edge = (state.conv_count % STEP_CYCLES) == (STEP_CYCLES - 1);

  // ****************************************************************
  // Control sequence
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_state.push = 1'b0;
    next_state.trig_sync = {state.trig_sync[1:0], i_conversion_trigger_n};
    next_state.sel_rd_sync0 = {1'b0, i_read_n, i_select_n};
    next_state.sel_rd_sync1 = state.sel_rd_sync0[1:0];
    // Remember a fall seen while the power-up pulse still runs
    if (trig_fall) begin
      next_state.fall_pending = 1'b1;
    end
    unique case (state.fsm)
      adc_ctrl_pkg::ST_DOWN: begin
        if (trig_rise) begin // RULE10
          next_state.fsm = adc_ctrl_pkg::ST_PWRUP;
          next_state.pu_count = '0; // RULE1
          next_state.fall_pending = 1'b0;
        end
      end
      adc_ctrl_pkg::ST_PWRUP: begin
        next_state.pu_count = PU_W'(state.pu_count + 1'b1); // RULE1
        if (32'(state.pu_count) == adc_ctrl_pkg::POWER_UP_CYCLES - 1) begin
          // Pulse over: start now if the fall already came
          next_state.fsm = (state.fall_pending || trig_fall) ?
                           adc_ctrl_pkg::ST_CONV : adc_ctrl_pkg::ST_IDLE; // RULE2
          next_state.conv_count = '0;
          next_state.bit_index = 3'd7;
          next_state.trial = 8'h80;
          next_state.fall_pending = 1'b0;
        end
      end
      adc_ctrl_pkg::ST_IDLE: begin
        next_state.fall_pending = 1'b0;
        if (trig_fall) begin // RULE2
          next_state.fsm = adc_ctrl_pkg::ST_CONV;
          next_state.conv_count = '0;
          next_state.bit_index = 3'd7;
          next_state.trial = 8'h80;
        end
      end
      adc_ctrl_pkg::ST_CONV: begin
        next_state.fall_pending = 1'b0;
        next_state.conv_count = CV_W'(state.conv_count + 1'b1); // RULE9
        if (step_edge) begin
          // Keep or drop the trial bit, then try the next one down
          if (!i_comparator) begin // RULE11
            next_state.trial[state.bit_index] = 1'b0;
          end
          if (state.bit_index != 3'd0) begin
            next_state.bit_index = 3'(state.bit_index - 1'b1);
            next_state.trial[3'(state.bit_index - 1'b1)] = 1'b1;
          end else begin
            next_state.fsm = adc_ctrl_pkg::ST_DONE;
            next_state.result = next_state.trial;
            next_state.push = 1'b1;
          end
        end
      end
      adc_ctrl_pkg::ST_DONE: begin
        // One cycle to decide power; the word waits here on back-pressure
        if (res_link.ready || !state.push) begin
          next_state.push = 1'b0;
          next_state.fsm = trig ? adc_ctrl_pkg::ST_IDLE   // RULE12
                                : adc_ctrl_pkg::ST_DOWN;  // RULE3
        end else begin
          next_state.push = 1'b1;
        end
      end
      default: next_state.fsm = adc_ctrl_pkg::ST_DOWN;
    endcase
  end

  // Powered down at reset, standing in for supply connection
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= '{fsm: adc_ctrl_pkg::ST_DOWN, // RULE10
                 trig_sync: 3'b000, sel_rd_sync0: 3'b011,
                 sel_rd_sync1: 2'b11, pu_count: '0,
                 fall_pending: 1'b0, conv_count: '0,
                 bit_index: 3'd7, trial: 8'h00,
                 result: adc_ctrl_pkg::RESULT_RESET, push: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Result path and outputs
  // ****************************************************************
  assign res_link.valid = state.push && (state.fsm == adc_ctrl_pkg::ST_DONE);
  assign res_link.data  = state.result;

  logic [7:0] buf_data;

  result_buffer #(.WIDTH(adc_ctrl_pkg::RESULT_WIDTH)) u_buffer (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .up      (res_link),
    .i_ready (read_en),
    .o_valid (o_result_valid),
    .o_data  (buf_data)
  );

  assign o_busy   = (state.fsm == adc_ctrl_pkg::ST_CONV); // RULE5
  assign o_powered = (state.fsm != adc_ctrl_pkg::ST_DOWN);
  assign o_track  = (state.fsm != adc_ctrl_pkg::ST_CONV); // RULE7
  assign o_dac_code = state.trial;
  // Newest result when none waits in the buffer
  assign o_result_bus = o_result_valid ? buf_data : state.result; // RULE4
  assign o_result_bus_oe = {8{read_en}}; // RULE6

endmodule

// ==== verification/analog_core_model.sv ====
// Comparator of the analog core, seen from the control logic.
// Assumes the trial code and the held level share one clock.
module analog_core_model (
  input  wire logic [7:0] i_dac_code,
  input  wire logic [7:0] i_level,
  output logic            o_keep
);
  timeunit 1ns;
  timeprecision 1ps;
  // Trial bit stays while the code is not above the held level
  assign o_keep = (i_dac_code <= i_level);
endmodule

// ==== verification/adc_ctrl_chk.sv ====
// Timing checks on the converter control ports.
// Assumes it is bound into the control block.
module adc_ctrl_chk (
  input wire logic       i_clock,
  input wire logic       i_nrst,
  input wire logic       i_conversion_trigger_n,
  input wire logic       i_select_n,
  input wire logic       i_read_n,
  input wire logic       o_busy,
  input wire logic       o_powered,
  input wire logic       o_track,
  input wire logic [7:0] o_result_bus_oe
);
  // ****
  // Busy run counter
  // ****
  localparam int STEP_N = 140;
  logic [10:0] busy_cnt;
  // Counts busy cycles; too long a run fails AST_BUSY_MAX well before the count wraps
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) busy_cnt <= 11'h000;
    else busy_cnt <= o_busy ? busy_cnt + 11'h001 : 11'h000;
  end
  // Powered-on cycles, saturating so back-to-back runs never wrap
  logic [10:0] pwr_cnt;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pwr_cnt <= 11'h000;
    end else if (!o_powered) begin
      pwr_cnt <= 11'h000;
    end else if (pwr_cnt != 11'h7FF) begin
      pwr_cnt <= pwr_cnt + 11'h001;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_rd_on;
    (!i_select_n && !i_read_n)[*4];
  endsequence
  sequence s_end_low;
    $fell(o_busy) && !i_conversion_trigger_n && !$past(i_conversion_trigger_n, 4);
  endsequence
  sequence s_end_high;
    $fell(o_busy) && i_conversion_trigger_n && $past(i_conversion_trigger_n, 4);
  endsequence
  AST_OE_ON: assert property (s_rd_on |-> o_result_bus_oe == 8'hFF)
    else $error("bus not driven");
  AST_OE_OFF: assert property (i_read_n[*4] |-> o_result_bus_oe == 8'h00)
    else $error("bus driven");
  AST_BUSY_MAX: assert property (o_busy |-> busy_cnt < adc_ctrl_pkg::CONV_CYCLES)
    else $error("conversion too long");
  AST_BUSY_FULL: assert property ($fell(o_busy) |-> busy_cnt == 11'(8 * STEP_N))
    else $error("busy run wrong");
  AST_TRACK: assert property (o_track != o_busy)
    else $error("track wrong");
  AST_PWRUP: assert property ($rose(o_busy) |-> pwr_cnt >= 11'(adc_ctrl_pkg::POWER_UP_CYCLES))
    else $error("busy in power-up");
  AST_WAKE: assert property ($rose(o_powered) |-> $past(i_conversion_trigger_n, 2))
    else $error("woke without trigger");
  AST_DOWN: assert property (s_end_low |-> ##[1:4] !o_powered)
    else $error("no power-down");
  AST_STAY: assert property (s_end_high |-> o_powered[*4])
    else $error("powered down");
endmodule
bind adc_ctrl adc_ctrl_chk chk_u (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_conversion_trigger_n(i_conversion_trigger_n), .i_select_n(i_select_n),
  .i_read_n(i_read_n), .o_busy(o_busy), .o_powered(o_powered),
  .o_track(o_track), .o_result_bus_oe(o_result_bus_oe));

// ==== verification/test_adc_ctrl.sv ====
// Self-checking bench for the converter control block.
// Assumes the analog core model answers each trial code.
module test_adc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, nrst, trig_n, select_n, read_n, keep;
  logic       busy, powered, track, valid;
  logic [7:0] level, dac, bus, oe;
  int         n_errors, n_tests, cycles;
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  adc_ctrl dut_u (.i_clock(clock), .i_nrst(nrst),
    .i_conversion_trigger_n(trig_n), .i_select_n(select_n),
    .i_read_n(read_n), .i_comparator(keep), .o_busy(busy),
    .o_powered(powered), .o_track(track), .o_dac_code(dac),
    .o_result_bus(bus), .o_result_bus_oe(oe), .o_result_valid(valid));
  analog_core_model core_u (.i_dac_code(dac), .i_level(level), .o_keep(keep));
  // ****
  // Helpers
  // ****
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy !== lvl && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  // Reads first word, then the last result once the buffer is empty
  task t_read(input logic [7:0] a, input logic [7:0] b);
    int n;
    check({7'h00, valid}, 8'h01);
    @(posedge clock);
    select_n <= 1'b0;
    read_n <= 1'b0;
    n = 0;
    do begin @(posedge clock); #1; n++; end while (oe !== 8'hFF && n < 8);
    check(bus, a);
    n = 0;
    while (valid !== 1'b0 && n < 8) begin @(posedge clock); #1; n++; end
    check(bus, b);
    @(posedge clock);
    select_n <= 1'b1;
    read_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check(oe, 8'h00);
  endtask
  // ****
  // Scenarios
  // ****
  // Fall inside the power-up pulse, then automatic power-down
  task t_slow(input logic [7:0] v);
    int n;
    @(posedge clock);
    level <= v;
    trig_n <= 1'b1;
    repeat (10) @(posedge clock);
    trig_n <= 1'b0;
    #1;
    wait_busy(1'b1, n);
    check(8'(n inside {[363:369]}), 8'h01);
    wait_busy(1'b0, n);
    check(8'(n <= adc_ctrl_pkg::CONV_CYCLES), 8'h01);
    repeat (6) @(posedge clock);
    #1;
    check({6'h00, powered, track}, 8'h01);
    t_read(v, v);
  endtask
  // Back-to-back conversions with trigger high at the end
  task t_fast(input logic [7:0] v1, input logic [7:0] v2);
    int n;
    @(posedge clock);
    level <= v1;
    trig_n <= 1'b1;
    repeat (400) @(posedge clock);
    for (int k = 0; k < 2; k++) begin
      trig_n <= 1'b0;
      #1;
      wait_busy(1'b1, n);
      check(8'(n <= 4), 8'h01);
      @(posedge clock);
      trig_n <= 1'b1;
      #1;
      wait_busy(1'b0, n);
      repeat (6) @(posedge clock);
      #1;
      check({7'h00, powered}, 8'h01);
      @(posedge clock);
      level <= v2;
      // Acquisition time after the conversion end and the input step
      repeat (25) @(posedge clock);
    end
    t_read(v1, v2);
  endtask
  task complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles > 10000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    {nrst, trig_n, select_n, read_n, level} = {4'b0011, 8'h00};
    {n_errors, n_tests, cycles} = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    #1;
    check({busy, powered, track, valid, oe[3:0]}, 8'h20);
    t_slow(8'hA5);
    t_slow(8'hFF);
    t_fast(8'h5A, 8'h01);
    complete_run();
  end
endmodule
